// ---- lmc_params.svh ----
// Constants of the LIN mode control and divider block
// Function
// R1 - Mute bit; software sets, wake-up clears
// R2 - Slave mode: mute frozen while receive full
// R3 - Send break; set-then-clear still gives one break
// R4 - Master mode break lasts 13 bit times
// R5 - Enable and slave bits select LIN mode
// R6 - Slave detects break after 11 low bits
// R7 - Slave mode: send break has no effect
// R8 - Slave mute: header method picks wake method
// R9 - Divider update immediate or at next character
// R10 - Deferred update without write keeps old divider
// R11 - Auto synch works only in slave mode
// R12 - Header on break or on break-synch-identifier
// R13 - Header interrupt follows flag when enabled
// R14 - Header flag cleared by status then control read
// R15 - Synch state set on break, software clear aborts
// R16 - Auto synch counts falling receive edges
// R17 - Mantissa 1-255; zero stops slave clocks
// R18 - Fraction in sixteenths; upper bits read zero
// R19 - Fraction written first, mantissa write updates
// R20 - Divider registers replace baud prescaler addresses
// R21 - Header length visible only when enabled
// R22 - Software avoids bit read-modify-write on divider
// R23 - Header length loaded on break, timeout, header
// R24 - Header length holds 57 minus header, quarters
// R25 - Header length register ignores writes
`ifndef LMC_PARAMS_SVH
`define LMC_PARAMS_SVH
`define LMC_A_STATUS 3'h0
`define LMC_A_MANT 3'h2
`define LMC_A_CR2 3'h4
`define LMC_A_CR3 3'h5
`define LMC_A_HLEN 3'h6
`define LMC_A_FRAC 3'h7
`define LMC_B_MUTE 1
`define LMC_B_BRK 0
`define LMC_B_DEFER 7
`define LMC_B_LINE 6
`define LMC_B_SLAVE 5
`define LMC_B_AUTO 4
`define LMC_B_HMETH 3
`define LMC_B_HIRQ 2
`define LMC_B_HFLAG 1
`define LMC_B_SYNC 0
`define LMC_RST8 8'h00
`define LMC_BRK_LIN 4'hd
`define LMC_BRK_DET 4'hb
`define LMC_SYNC_EDGES 3'h5
`define LMC_HLEN_MAX_Q4 8'he4
`define LMC_HLEN_BRK 8'hff
`define LMC_HLEN_TMO 8'h00
`endif

// ---- lmc_pkg.sv ----
// Types of the LIN mode control and divider block
package lmc_pkg;
    // Header tracking states, one-hot
    typedef enum logic [2:0] {
        LMC_IDLE = 3'b001,
        LMC_SYNC = 3'b010,
        LMC_IDW = 3'b100
    } lmc_state_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0] cr2;        // Control two
        logic [7:0] cr3;        // Control three
        logic [3:0] frac_w;     // Staged fraction
        logic [11:0] div;       // Active divider
        logic [11:0] pend;      // Deferred divider
        logic pend_v;           // Deferred write seen
        logic [7:0] hlen;       // Header length
        logic status_seen;      // First half of flag clear
        lmc_state_t state;      // Header tracking
        logic [3:0] low_cnt;    // Low bit times
        logic [2:0] edge_cnt;   // Synch falling edges
        logic rx_meta;          // Sync stage one
        logic rx_sync;          // Sync stage two
        logic rx_prev;          // Edge history
        logic rxf_prev; // Receive full history
        logic [7:0] rdata;      // Read data
        logic brk_req;          // Break request out
        logic [3:0] brk_bits;   // Break length out
        logic clk_en;           // Baud clocks on
        logic wake_m;           // Wake method out
        logic par_act;          // Parity check out
        logic irq;              // Header interrupt out
        logic sync_act; // Auto synch counting out
    } lmc_regs_t;
endpackage

// ---- lmc_lin_ctrl.sv ----
// LIN mode control, slave divider and header tracking
`timescale 1ns/10ps
`include "lmc_params.svh"
module lmc_lin_ctrl #(
    parameter logic [3:0] SCI_BRK_BITS = 4'ha // Break length outside LIN
) (
    input wire logic clock,              // 100 MHz clock
    input wire logic rst,                // Async reset, high
    input wire logic [2:0] addr,         // Register address
    input wire logic [7:0] wdata,        // Write data
    input wire logic wr,                 // Write strobe
    input wire logic rd,                 // Read strobe
    output logic [7:0] rdata,            // Read data, next cycle
    input wire logic serial_rx_in,       // Receive pin
    input wire logic bit_tick,           // One pulse per bit time
    input wire logic receive_full_flag,  // Receive data full
    input wire logic wake_up_det,        // Wake-up recognised pulse
    input wire logic wake_bit_in,        // Ordinary wake method
    input wire logic parity_check_enable, // Parity control bit
    input wire logic break_done,         // Transmitter sent a break
    input wire logic synch_update, // Auto synch result pulse
    input wire logic [11:0] synch_divider, // Auto synch divider
    input wire logic [7:0] header_dur_q4, // Header time, quarter bits
    input wire logic header_timeout,     // Header timeout pulse
    output logic [11:0] baud_divider,    // Active divider
    output logic baud_clk_en,            // Baud clocks running
    output logic receiver_mute,          // Mute mode
    output logic break_req,              // Send a break word
    output logic [3:0] break_bits,       // Break length, bit times
    output logic wake_method,            // Wake method in use
    output logic parity_check_active,    // Identifier parity on
    output logic header_irq,             // Header interrupt
    output logic synch_counting // Synch edges being counted
);
    import lmc_pkg::*;

    lmc_regs_t s_r; // Registered state
    lmc_regs_t s_nxt; // Next state
    logic line_w; // LIN enabled
    logic slave_w; // LIN slave mode
    logic master_w; // LIN master mode
    logic rxf_rise; // New character received
    logic fall_edge; // Falling edge on receive line
    logic brk_det; // Synch break recognised
    logic hlen_vis; // Header length readable
    logic sw_sync_abort; // Software aborts synch field

    // Mode decode from control three
    assign line_w = s_r.cr3[`LMC_B_LINE]; // [R5]
    assign slave_w = line_w & s_r.cr3[`LMC_B_SLAVE]; // [R5]
    assign master_w = line_w & ~s_r.cr3[`LMC_B_SLAVE]; // [R5]
    assign rxf_rise = receive_full_flag & ~s_r.rxf_prev;
    // Edge taken from the second stage only
    assign fall_edge = s_r.rx_prev & ~s_r.rx_sync;
    // Eleventh low bit time completes the break
    assign brk_det = slave_w & bit_tick & ~s_r.rx_sync &
        (s_r.low_cnt == (`LMC_BRK_DET - 4'h1)); // [R6]
    assign hlen_vis = slave_w &
        (s_r.cr3[`LMC_B_AUTO] | s_r.cr3[`LMC_B_HMETH]); // [R21]
    assign sw_sync_abort = wr & (addr == `LMC_A_CR3) &
        ~wdata[`LMC_B_SYNC]; // [R15]

    // Register read mux, answered one cycle later
    function automatic logic [7:0] rd_mux(input logic [2:0] a,
                                          input lmc_regs_t st,
                                          input logic sl,
                                          input logic vis);
        logic [7:0] v;
        v = `LMC_RST8;
        unique case (a)
            `LMC_A_CR2: v = st.cr2;
            `LMC_A_CR3: v = st.cr3;
            // Divider registers read the active divider
            `LMC_A_MANT: v = sl ? st.div[11:4] : `LMC_RST8; // [R20]
            `LMC_A_FRAC: v = sl ? {4'h0, st.div[3:0]} : `LMC_RST8; // [R18]
            `LMC_A_HLEN: v = vis ? st.hlen : `LMC_RST8; // [R21]
            default: v = `LMC_RST8; // Status and unmapped read zero
        endcase
        return v;
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        s_nxt = s_r;
        // Receive pin synchroniser and histories
        s_nxt.rx_meta = serial_rx_in;
        s_nxt.rx_sync = s_r.rx_meta;
        s_nxt.rx_prev = s_r.rx_sync;
        s_nxt.rxf_prev = receive_full_flag;
        s_nxt.rdata = rd ? rd_mux(addr, s_r, slave_w, hlen_vis)
                         : `LMC_RST8;

        // Low bit counter saturates so a long low gives one break
        if (s_r.rx_sync) begin
            s_nxt.low_cnt = 4'h0;
        end else if (bit_tick && s_r.low_cnt != `LMC_BRK_DET) begin
            s_nxt.low_cnt = s_r.low_cnt + 4'h1; // [R6]
        end

        // Hardware clears mute on wake-up
        if (wake_up_det) begin
            s_nxt.cr2[`LMC_B_MUTE] = 1'b0; // [R1]
        end

        // Deferred method is cleared by each received character in slave mode
        if (rxf_rise && slave_w) begin
            s_nxt.cr3[`LMC_B_DEFER] = 1'b0; // [R9]
        end

        // Control two write; mute locked in slave mode while receive full
        if (wr && addr == `LMC_A_CR2) begin
            s_nxt.cr2[7:2] = wdata[7:2];
            s_nxt.cr2[`LMC_B_BRK] = wdata[`LMC_B_BRK]; // [R3]
            if (!(slave_w && receive_full_flag)) begin
                s_nxt.cr2[`LMC_B_MUTE] = wdata[`LMC_B_MUTE]; // [R1] [R2]
            end
        end

        // Control three write; flag bits are not written directly
        if (wr && addr == `LMC_A_CR3) begin
            s_nxt.cr3[7:2] = wdata[7:2]; // [R5]
        end

        // Header length has no write path: writes are dropped [R25]
        // Fraction is staged until the mantissa write
        if (wr && addr == `LMC_A_FRAC && slave_w) begin
            s_nxt.frac_w = wdata[3:0]; // [R18] [R19]
        end

        // Deferred update at the next character, old value if no write
        if (rxf_rise && slave_w && s_r.cr3[`LMC_B_DEFER]) begin
            if (s_r.pend_v) begin
                s_nxt.div = s_r.pend; // [R9]
            end
            s_nxt.pend_v = 1'b0; // [R10]
        end

        // Mantissa write loads now or arms the deferred update
        if (wr && addr == `LMC_A_MANT && slave_w) begin
            if (s_r.cr3[`LMC_B_DEFER]) begin
                s_nxt.pend = {wdata, s_r.frac_w}; // [R9]
                s_nxt.pend_v = 1'b1;
            end else if (!(synch_update && s_r.cr3[`LMC_B_AUTO])) begin
                s_nxt.div = {wdata, s_r.frac_w}; // [R9] [R19]
            end
        end

        // Auto synch result wins over a coinciding software write
        if (synch_update && slave_w && s_r.cr3[`LMC_B_AUTO]) begin
            s_nxt.div = synch_divider; // [R11]
        end

        // Flag clear sequence: status access arms, control read clears
        if ((wr || rd) && addr == `LMC_A_STATUS) begin
            s_nxt.status_seen = 1'b1; // [R14]
        end else if (rd && addr == `LMC_A_CR3 && s_r.status_seen) begin
            s_nxt.status_seen = 1'b0;
            s_nxt.cr3[`LMC_B_HFLAG] = 1'b0; // [R14]
        end

        // Header tracking
        unique case (s_r.state)
            LMC_IDLE: begin
                s_nxt.edge_cnt = 3'h0;
            end
            LMC_SYNC: begin
                if (s_r.cr3[`LMC_B_AUTO]) begin
                    // Auto synch counts the synch field edges
                    if (fall_edge) begin
                        s_nxt.edge_cnt = s_r.edge_cnt + 3'h1; // [R16]
                        if (s_r.edge_cnt == `LMC_SYNC_EDGES - 3'h1) begin
                            s_nxt.cr3[`LMC_B_SYNC] = 1'b0; // [R15]
                            s_nxt.state = s_r.cr3[`LMC_B_HMETH] ?
                                LMC_IDW : LMC_IDLE; // [R12]
                        end
                    end
                end else if (rxf_rise) begin
                    // Without auto synch the field is a plain character
                    s_nxt.cr3[`LMC_B_SYNC] = 1'b0; // [R15]
                    s_nxt.state = s_r.cr3[`LMC_B_HMETH] ?
                        LMC_IDW : LMC_IDLE; // [R12]
                end
            end
            LMC_IDW: begin
                // Identifier completes the header
                if (rxf_rise) begin
                    s_nxt.cr3[`LMC_B_HFLAG] = 1'b1; // [R12] [R14]
                    s_nxt.hlen = `LMC_HLEN_MAX_Q4 - header_dur_q4; // [R23] [R24]
                    s_nxt.state = LMC_IDLE;
                end
            end
            default: begin
                s_nxt.state = LMC_IDLE;
            end
        endcase

        // Software abort of the synch field returns to idle
        if (sw_sync_abort && s_r.cr3[`LMC_B_SYNC]) begin
            s_nxt.cr3[`LMC_B_SYNC] = 1'b0; // [R15]
            s_nxt.state = LMC_IDLE;
        end

        // Timeout ends a header and marks the length
        if (header_timeout && slave_w) begin
            s_nxt.hlen = `LMC_HLEN_TMO; // [R23]
            s_nxt.cr3[`LMC_B_SYNC] = 1'b0;
            s_nxt.state = LMC_IDLE;
        end

        // A break starts a header; it wins over abort and timeout
        if (brk_det) begin
            s_nxt.cr3[`LMC_B_SYNC] = 1'b1; // [R15]
            s_nxt.hlen = `LMC_HLEN_BRK; // [R23]
            s_nxt.edge_cnt = 3'h0;
            s_nxt.state = LMC_SYNC;
            if (!s_r.cr3[`LMC_B_HMETH]) begin
                s_nxt.cr3[`LMC_B_HFLAG] = 1'b1; // [R12]
            end
        end

        // Outside slave mode the header logic is held idle
        if (!slave_w) begin
            s_nxt.state = LMC_IDLE;
            s_nxt.cr3[`LMC_B_SYNC] = 1'b0;
        end

        // Break request held until the transmitter sends it
        s_nxt.brk_req = (s_r.cr2[`LMC_B_BRK] |
            (s_r.brk_req & ~break_done)) & ~slave_w; // [R3] [R7]
        s_nxt.brk_bits = master_w ? `LMC_BRK_LIN : SCI_BRK_BITS; // [R4]
        // Zero mantissa stops the slave baud clocks
        s_nxt.clk_en = ~slave_w | (s_r.div[11:4] != `LMC_RST8); // [R17]
        s_nxt.wake_m = (slave_w & s_r.cr2[`LMC_B_MUTE]) ?
            s_r.cr3[`LMC_B_HMETH] : wake_bit_in; // [R8]
        s_nxt.par_act = line_w & parity_check_enable; // [R8]
        s_nxt.irq = s_r.cr3[`LMC_B_HIRQ] & s_r.cr3[`LMC_B_HFLAG]; // [R13]
        s_nxt.sync_act = slave_w & s_r.cr3[`LMC_B_AUTO] &
            s_r.cr3[`LMC_B_SYNC]; // [R11] [R16]
    end

    // State register; constants only at reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '{cr2: `LMC_RST8, cr3: `LMC_RST8, frac_w: 4'h0,
                     div: 12'h000, pend: 12'h000, pend_v: 1'b0,
                     hlen: `LMC_RST8, status_seen: 1'b0,
                     state: LMC_IDLE, low_cnt: 4'h0, edge_cnt: 3'h0,
                     rx_meta: 1'b1, rx_sync: 1'b1, rx_prev: 1'b1,
                     rxf_prev: 1'b0, rdata: `LMC_RST8, brk_req: 1'b0,
                     brk_bits: SCI_BRK_BITS, clk_en: 1'b1, wake_m: 1'b0,
                     par_act: 1'b0, irq: 1'b0, sync_act: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign rdata = s_r.rdata;
    assign baud_divider = s_r.div;
    assign baud_clk_en = s_r.clk_en;
    assign receiver_mute = s_r.cr2[`LMC_B_MUTE];
    assign break_req = s_r.brk_req;
    assign break_bits = s_r.brk_bits;
    assign wake_method = s_r.wake_m;
    assign parity_check_active = s_r.par_act;
    assign header_irq = s_r.irq;
    assign synch_counting = s_r.sync_act;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    mute_lock_a: assert property ( // [R2]
        (slave_w && receive_full_flag && wr && addr == `LMC_A_CR2 &&
         !wake_up_det) |=> $stable(receiver_mute))
        else $error("mute changed while receive full");
    slave_nobrk_a: assert property ( // [R7]
        slave_w |=> !break_req)
        else $error("break requested in slave mode");
    master_len_a: assert property ( // [R4]
        master_w |=> break_bits == `LMC_BRK_LIN)
        else $error("master break not 13 bits");
    irq_follow_a: assert property ( // [R13]
        (s_r.cr3[`LMC_B_HIRQ] && s_r.cr3[`LMC_B_HFLAG]) |=> header_irq)
        else $error("header interrupt missing");
    brk_hdr_a: assert property ( // [R12]
        (brk_det && !s_r.cr3[`LMC_B_HMETH]) |=>
        s_r.cr3[`LMC_B_HFLAG] && s_r.cr3[`LMC_B_SYNC])
        else $error("break did not flag header");
    brk_hlen_a: assert property ( // [R23]
        brk_det |=> s_r.hlen == `LMC_HLEN_BRK)
        else $error("header length not loaded on break");
    sync_abort_a: assert property ( // [R15]
        (sw_sync_abort && !brk_det) |=>
        !s_r.cr3[`LMC_B_SYNC] && s_r.state == LMC_IDLE)
        else $error("synch abort did not return to idle");
    hlen_hide_a: assert property ( // [R21]
        (rd && addr == `LMC_A_HLEN && !hlen_vis) |=> rdata == `LMC_RST8)
        else $error("hidden header length read nonzero");
    div_now_a: assert property ( // [R9]
        (slave_w && wr && addr == `LMC_A_MANT && !s_r.cr3[`LMC_B_DEFER] &&
         !synch_update) |=> baud_divider == {$past(wdata), $past(s_r.frac_w)})
        else $error("immediate divider update missed");
    div_keep_a: assert property ( // [R10]
        (slave_w && rxf_rise && s_r.cr3[`LMC_B_DEFER] && !s_r.pend_v &&
         !synch_update && !wr) |=> $stable(baud_divider))
        else $error("deferred update changed divider without write");
endmodule // lmc_lin_ctrl

// ---- lmc_lin_node.sv ----
// Far-side LIN bus node model: bit timing and the receive line
`timescale 1ns/10ps
module lmc_lin_node #(
    parameter int TICK_CYC = 4 // Clock cycles per bit time
) (
    input wire logic clock, // System clock
    input wire logic rst, // Async reset, high
    output logic serial_rx_in, // Bus level at the receiver
    output logic bit_tick // One pulse per bit time
);
    int tick_cnt; // Bit time divider

    // Free-running bit timing, as the receiver's baud clock would give
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_cnt <= 0;
            bit_tick <= 1'b0;
        end else begin
            tick_cnt <= (tick_cnt == TICK_CYC - 1) ? 0 : tick_cnt + 1;
            bit_tick <= (tick_cnt == TICK_CYC - 1);
        end
    end

    // The bus pull-up holds the recessive level when nobody drives
    initial serial_rx_in = 1'b1;

    // Dominant break of n bit times; a master sends 13
    task automatic send_break(input int n);
        @(posedge clock);
        serial_rx_in <= 1'b0;
        repeat (n) @(posedge bit_tick);
        @(posedge clock);
        serial_rx_in <= 1'b1;
    endtask

    // Synch field falling edges, slow enough to pass the 2-FF stage
    task automatic send_edges(input int n);
        repeat (n) begin
            repeat (TICK_CYC) @(posedge clock);
            serial_rx_in <= 1'b0;
            repeat (TICK_CYC) @(posedge clock);
            serial_rx_in <= 1'b1;
        end
    endtask
endmodule // lmc_lin_node

// ---- tb_lmc_lin_ctrl.sv ----
// Self-checking testbench of the LIN mode control block
`timescale 1ns/10ps
`include "lmc_params.svh"
module tb_lmc_lin_ctrl;
    import lmc_pkg::*;
    logic clock = 1'b0; // 100 MHz clock
    logic rst = 1'b1; // Reset, high
    logic [2:0] addr = 3'h0; // Register address
    logic [7:0] wdata = 8'h00; // Write data
    logic wr = 1'b0; // Write strobe
    logic rd = 1'b0; // Read strobe
    logic receive_full_flag = 1'b0; // Receive data full
    logic wake_up_det = 1'b0; // Wake-up pulse
    logic wake_bit_in = 1'b1; // Ordinary wake method
    logic parity_check_enable = 1'b1; // Parity control
    logic break_done = 1'b0; // Break word sent
    logic synch_update = 1'b0; // Auto synch result
    logic [11:0] synch_divider = 12'h155; // Auto synch divider
    logic [7:0] header_dur_q4 = 8'h50; // Header time
    logic header_timeout = 1'b0; // Header timeout
    logic serial_rx_in, bit_tick; // From the bus model
    logic [7:0] rdata; // Read data
    logic [11:0] baud_divider; // Active divider
    logic baud_clk_en, receiver_mute, break_req; // Outputs
    logic [3:0] break_bits; // Break length
    logic wake_method, parity_check_active; // Outputs
    logic header_irq, synch_counting; // Outputs
    int bad_count = 0; // Mismatches
    int check_count = 0; // Comparisons

    always #5 clock = ~clock;

    lmc_lin_ctrl i_dut (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
        .serial_rx_in, .bit_tick, .receive_full_flag, .wake_up_det,
        .wake_bit_in, .parity_check_enable, .break_done, .synch_update,
        .synch_divider, .header_dur_q4, .header_timeout, .baud_divider,
        .baud_clk_en, .receiver_mute, .break_req, .break_bits,
        .wake_method, .parity_check_active, .header_irq, .synch_counting);

    lmc_lin_node i_node (.clock, .rst, .serial_rx_in, .bit_tick);

    // Compare one value, report at once on a mismatch
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    // Let n edges pass, then sample off the edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Plain byte write; never bit read-modify-write
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // Read; data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // One received character: a rise of the full flag
    task automatic pulse_full;
        @(posedge clock);
        receive_full_flag <= 1'b1;
        @(posedge clock);
        receive_full_flag <= 1'b0;
        step(2);
    endtask

    // Print the counts and the verdict, then stop
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog: the tests need a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_of_test;
    end

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        step(1);
        // Reset state and an unmapped address
        rd_chk(`LMC_A_CR2, 8'h00);
        rd_chk(`LMC_A_CR3, 8'h00);
        rd_chk(3'h1, 8'h00);
        chk(baud_clk_en, 16'h1);
        chk(parity_check_active, 16'h0);
        wr_reg(`LMC_A_MANT, 8'h33); // Ignored outside slave mode
        step(2);
        chk(baud_divider, 16'h0);
        // Master break: 13 bits, held past the clear until sent
        wr_reg(`LMC_A_CR3, 8'h40);
        wr_reg(`LMC_A_CR2, 8'h01);
        step(2);
        chk(break_req, 16'h1);
        chk(break_bits, 16'hd);
        chk(parity_check_active, 16'h1);
        @(posedge clock) parity_check_enable <= 1'b0;
        step(2);
        chk(parity_check_active, 16'h0);
        wr_reg(`LMC_A_CR2, 8'h00);
        step(2);
        chk(break_req, 16'h1);
        @(posedge clock) break_done <= 1'b1;
        @(posedge clock) break_done <= 1'b0;
        step(2);
        chk(break_req, 16'h0);
        wr_reg(`LMC_A_CR3, 8'h20); // Slave bit alone stays disabled
        step(2);
        chk(break_bits, 16'ha);
        // Slave mode: break request has no effect
        wr_reg(`LMC_A_CR3, 8'h60);
        wr_reg(`LMC_A_CR2, 8'h03);
        step(2);
        chk(break_req, 16'h0);
        chk(receiver_mute, 16'h1);
        // Wake method follows header method while muted in slave
        wr_reg(`LMC_A_CR3, 8'h68);
        step(2);
        chk(wake_method, 16'h1);
        wr_reg(`LMC_A_CR3, 8'h60);
        step(2);
        chk(wake_method, 16'h0);
        @(posedge clock) wake_up_det <= 1'b1;
        @(posedge clock) wake_up_det <= 1'b0;
        step(2);
        chk(receiver_mute, 16'h0);
        chk(wake_method, 16'h1);
        // Mute frozen both ways while receive data is full
        @(posedge clock) receive_full_flag <= 1'b1;
        wr_reg(`LMC_A_CR2, 8'h02);
        step(2);
        chk(receiver_mute, 16'h0);
        @(posedge clock) receive_full_flag <= 1'b0;
        wr_reg(`LMC_A_CR2, 8'h02);
        @(posedge clock) receive_full_flag <= 1'b1;
        wr_reg(`LMC_A_CR2, 8'h00);
        step(2);
        chk(receiver_mute, 16'h1);
        @(posedge clock) receive_full_flag <= 1'b0;
        wr_reg(`LMC_A_CR2, 8'h00);
        // Divider: fraction staged, mantissa write updates
        wr_reg(`LMC_A_FRAC, 8'hf5);
        rd_chk(`LMC_A_FRAC, 8'h00);
        wr_reg(`LMC_A_MANT, 8'h1b);
        step(2);
        chk(baud_divider, 16'h1b5);
        rd_chk(`LMC_A_FRAC, 8'h05);
        rd_chk(`LMC_A_MANT, 8'h1b);
        wr_reg(`LMC_A_MANT, 8'h00);
        step(2);
        chk(baud_clk_en, 16'h0);
        // Auto synch result is ignored until auto synch is enabled
        @(posedge clock) synch_update <= 1'b1;
        @(posedge clock) synch_update <= 1'b0;
        step(2);
        chk(baud_divider, 16'h005);
        wr_reg(`LMC_A_CR3, 8'h70);
        @(posedge clock) synch_update <= 1'b1;
        @(posedge clock) synch_update <= 1'b0;
        step(2);
        chk(baud_divider, 16'h155);
        chk(baud_clk_en, 16'h1);
        // Deferred update at the next character
        wr_reg(`LMC_A_CR3, 8'he0);
        wr_reg(`LMC_A_FRAC, 8'h03);
        wr_reg(`LMC_A_MANT, 8'h20);
        step(2);
        chk(baud_divider, 16'h155);
        pulse_full;
        chk(baud_divider, 16'h203);
        rd_chk(`LMC_A_CR3, 8'h60);
        wr_reg(`LMC_A_CR3, 8'he0);
        pulse_full;
        chk(baud_divider, 16'h203);
        // Header on break, interrupt on, length hidden
        wr_reg(`LMC_A_CR3, 8'h64);
        i_node.send_break(13);
        step(3);
        chk(header_irq, 16'h1);
        chk(synch_counting, 16'h0);
        rd_chk(`LMC_A_HLEN, 8'h00);
        rd_chk(`LMC_A_STATUS, 8'h00);
        rd_chk(`LMC_A_CR3, 8'h67);
        rd_chk(`LMC_A_CR3, 8'h65);
        step(2);
        chk(header_irq, 16'h0);
        wr_reg(`LMC_A_CR3, 8'h64);
        rd_chk(`LMC_A_CR3, 8'h64);
        // Identifier method with auto synch, interrupt masked
        wr_reg(`LMC_A_CR3, 8'h78);
        i_node.send_break(13);
        step(3);
        chk(synch_counting, 16'h1);
        rd_chk(`LMC_A_HLEN, 8'hff);
        rd_chk(`LMC_A_CR3, 8'h79);
        i_node.send_edges(5);
        step(3);
        chk(synch_counting, 16'h0);
        pulse_full;
        rd_chk(`LMC_A_CR3, 8'h7a);
        chk(header_irq, 16'h0);
        rd_chk(`LMC_A_HLEN, 8'h94);
        wr_reg(`LMC_A_HLEN, 8'h12);
        rd_chk(`LMC_A_HLEN, 8'h94);
        @(posedge clock) header_timeout <= 1'b1;
        @(posedge clock) header_timeout <= 1'b0;
        rd_chk(`LMC_A_HLEN, 8'h00);
        end_of_test;
    end
endmodule // tb_lmc_lin_ctrl
